// ==== hw/io_register_space_decode.v ====
// i/o register window decode with bit access, write-one-to-clear flags and data-space alias
//
// Overview of operation
// RQ1: software should write zeros into reserved bit positions of any register it writes.
// RQ2: software must never write to a reserved i/o address, whose result is undefined.
// RQ3: any single bit of a register at i/o addresses 00..1f can be set or cleared directly.
// RQ4: one chosen bit of a low-range register can be tested to skip on set or on clear.
// RQ5: some status flags clear when a one is written to them and ignore a written zero.
// RQ6: bit set and clear is a read-modify-write of the whole register, clearing set flags.
// RQ7: bit set and clear reach only addresses 00..1f, never the higher i/o registers.
// RQ8: the i/o read and write access uses i/o addresses 00..3f, 64 locations in all.
// RQ9: data-space loads and stores see each i/o register at its i/o address plus 20.
// RQ10: the extended region 60..ff is reached only by data-space loads and stores.
// RQ11: reserved addresses and bits read as zero, and writes to reserved bits do nothing.
`timescale 1ns/1ns
`include "io_space_regs.vh"

module io_register_space_decode #(
	parameter DW = 8
) (
	input  wire          SYS_CLK,
	input  wire          SYS_RST,
	input  wire [5:0]    IO_ADDR,
	input  wire          IO_RD,
	input  wire          IO_WR,
	input  wire [DW-1:0] IO_WDATA,
	input  wire [4:0]    BIT_ADDR,
	input  wire [2:0]    BIT_SEL,
	input  wire          SET_IO_BIT,
	input  wire          CLEAR_IO_BIT,
	input  wire          SKIP_IF_IO_BIT_SET,
	input  wire          SKIP_IF_IO_BIT_CLEAR,
	input  wire [7:0]    DS_ADDR,
	input  wire          DS_RD,
	input  wire          DS_WR,
	input  wire [DW-1:0] DS_WDATA,
	input  wire [DW-1:0] EXT_RDATA,
	input  wire [DW-1:0] PIN_A,
	input  wire [DW-1:0] PIN_B,
	input  wire [DW-1:0] PIN_C,
	input  wire [DW-1:0] PIN_D,
	input  wire [DW-1:0] TIMER0_EVENTS,
	input  wire [DW-1:0] TIMER1_EVENTS,
	input  wire [DW-1:0] TIMER2_EVENTS,
	input  wire [DW-1:0] PIN_CHG_EVENTS,
	input  wire [DW-1:0] EXT_IRQ_EVENTS,
	input  wire          COMP_EVENT,
	output wire [7:0]    EXT_ADDR,
	output wire          EXT_RD,
	output wire          EXT_WR,
	output wire [DW-1:0] EXT_WDATA,
	output wire [DW-1:0] READ_DATA,
	output wire          READ_VALID,
	output wire          SKIP,
	output wire          TEST_DONE,
	output wire [DW-1:0] PORT_A_DIR,
	output wire [DW-1:0] PORT_A_OUT,
	output wire [DW-1:0] PORT_B_DIR,
	output wire [DW-1:0] PORT_B_OUT,
	output wire [DW-1:0] PORT_C_DIR,
	output wire [DW-1:0] PORT_C_OUT,
	output wire [DW-1:0] PORT_D_DIR,
	output wire [DW-1:0] PORT_D_OUT,
	output wire [DW-1:0] EXT_IRQ_MASK,
	output wire [DW-1:0] EXT_IRQ_FLAGS
);

////////////////////////////////////////////////////////////////////////////////
// decode functions

// plain writable bits per address
function [DW-1:0] wr_mask;
	input [5:0] a;
	begin
		// port direction and output
		if (a == `A_PORT_A_DIR)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_A_OUT)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_B_DIR)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_B_OUT)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_C_DIR)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_C_OUT)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_D_DIR)
			wr_mask = `M_FULL;
		else if (a == `A_PORT_D_OUT)
			wr_mask = `M_FULL;
		// scratch
		else if (a == `A_SCRATCH_0)
			wr_mask = `M_FULL;
		else if (a == `A_SCRATCH_1)
			wr_mask = `M_FULL;
		else if (a == `A_SCRATCH_2)
			wr_mask = `M_FULL;
		// eeprom data and address
		else if (a == `A_EEPROM_DATA)
			wr_mask = `M_FULL;
		else if (a == `A_EEPROM_ADDR_LO)
			wr_mask = `M_FULL;
		else if (a == `A_EEPROM_ADDR_HI)
			wr_mask = `M_FULL;
		// timer0 count and compares
		else if (a == `A_TIMER0_COUNT)
			wr_mask = `M_FULL;
		else if (a == `A_TIMER0_CMP_A)
			wr_mask = `M_FULL;
		else if (a == `A_TIMER0_CMP_B)
			wr_mask = `M_FULL;
		// serial, debug and self-programming
		else if (a == `A_SERIAL_CTRL)
			wr_mask = `M_FULL;
		else if (a == `A_SERIAL_DATA)
			wr_mask = `M_FULL;
		else if (a == `A_DEBUG_DATA)
			wr_mask = `M_FULL;
		else if (a == `A_SELF_PROG_CTRL)
			wr_mask = `M_FULL;
		// registers with reserved or flag bits
		else if (a == `A_EXT_IRQ_MASK)
			wr_mask = `M_EXT_IRQ_MASK;
		else if (a == `A_EEPROM_CTRL)
			wr_mask = `M_EEPROM_CTRL;
		else if (a == `A_GLOBAL_TMR_CTRL)
			wr_mask = `M_GLOBAL_TMR_CTRL;
		else if (a == `A_TIMER0_CTRL_A)
			wr_mask = `M_TIMER0_CTRL_A;
		else if (a == `A_TIMER0_CTRL_B)
			wr_mask = `M_TIMER0_CTRL_B;
		else if (a == `A_SERIAL_STATUS)
			wr_mask = `M_SERIAL_STATUS;
		else if (a == `A_COMP_CTRL_STAT)
			wr_mask = `M_COMP_CTRL_RW;
		else if (a == `A_SLEEP_CTRL)
			wr_mask = `M_SLEEP_CTRL;
		else if (a == `A_RESET_CAUSE)
			wr_mask = `M_RESET_CAUSE;
		else if (a == `A_CORE_CTRL)
			wr_mask = `M_CORE_CTRL;
		// read-only pins, flag registers and reserved addresses
		else
			wr_mask = `M_NONE; // RQ11
	end
endfunction

// write-one-to-clear flag bits per address
function [DW-1:0] w1c_mask;
	input [5:0] a;
	begin
		if (a == `A_TIMER0_FLAGS)
			w1c_mask = `M_TIMER0_FLAGS;
		else if (a == `A_TIMER1_FLAGS)
			w1c_mask = `M_TIMER1_FLAGS;
		else if (a == `A_TIMER2_FLAGS)
			w1c_mask = `M_TIMER2_FLAGS;
		else if (a == `A_PIN_CHG_FLAGS)
			w1c_mask = `M_PIN_CHG_FLAGS;
		else if (a == `A_EXT_IRQ_FLAGS)
			w1c_mask = `M_EXT_IRQ_FLAGS;
		else if (a == `A_COMP_CTRL_STAT)
			w1c_mask = `M_COMP_CTRL_W1C;
		else
			w1c_mask = `M_NONE;
	end
endfunction

// hardware events that set flag bits
function [DW-1:0] evt_bits;
	input [5:0] a;
	begin
		if (a == `A_TIMER0_FLAGS)
			evt_bits = TIMER0_EVENTS;
		else if (a == `A_TIMER1_FLAGS)
			evt_bits = TIMER1_EVENTS;
		else if (a == `A_TIMER2_FLAGS)
			evt_bits = TIMER2_EVENTS;
		else if (a == `A_PIN_CHG_FLAGS)
			evt_bits = PIN_CHG_EVENTS;
		else if (a == `A_EXT_IRQ_FLAGS)
			evt_bits = EXT_IRQ_EVENTS;
		else if (a == `A_COMP_CTRL_STAT)
			evt_bits = {DW{COMP_EVENT}};
		else
			evt_bits = `M_NONE;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// storage

reg  [DW-1:0] mem_ff [0:63];
reg  [DW-1:0] read_data_ff;
reg           read_valid_ff;
reg           skip_ff;
reg           test_done_ff;

// current value as the core sees it
function [DW-1:0] rd_value;
	input [5:0] a;
	begin
		if (a == `A_PORT_A_PIN)
			rd_value = PIN_A;
		else if (a == `A_PORT_B_PIN)
			rd_value = PIN_B;
		else if (a == `A_PORT_C_PIN)
			rd_value = PIN_C;
		else if (a == `A_PORT_D_PIN)
			rd_value = PIN_D;
		else if ((wr_mask(a) | w1c_mask(a)) == `M_NONE)
			rd_value = `M_NONE; // RQ11
		else
			rd_value = mem_ff[a] & (wr_mask(a) | w1c_mask(a)); // RQ11
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// access decode

// data-space regions
localparam [1:0] R_CORE = 2'b00;
localparam [1:0] R_IO   = 2'b01;
localparam [1:0] R_EXT  = 2'b10;

// data-space region of an address
function [1:0] ds_region;
	input [7:0] a;
	begin
		if (a < `DS_IO_BASE)
			ds_region = R_CORE;
		else if (a < `DS_EXT_BASE)
			ds_region = R_IO; // RQ9
		else
			ds_region = R_EXT; // RQ10
	end
endfunction

wire [7:0]    ds_off    = DS_ADDR - `DS_IO_BASE;
wire          ds_io_hit = (ds_region(DS_ADDR) == R_IO); // RQ9
wire          ds_ext    = (ds_region(DS_ADDR) == R_EXT); // RQ10
wire [5:0]    ds_io     = ds_off[5:0]; // RQ9
wire [5:0]    bit_io    = {1'b0, BIT_ADDR}; // RQ7
wire [DW-1:0] sel_mask  = {{(DW-1){1'b0}}, 1'b1} << BIT_SEL;
wire [DW-1:0] bit_cur   = rd_value(bit_io);
wire          bit_op    = SET_IO_BIT | CLEAR_IO_BIT;
wire          test_req  = SKIP_IF_IO_BIT_SET | SKIP_IF_IO_BIT_CLEAR;
wire          bit_hi    = ((bit_cur & sel_mask) != `M_NONE); // RQ4

reg  [5:0]    acc_addr;
reg           acc_wr;
reg  [DW-1:0] acc_data;

// one write per cycle: bit op, then i/o write, then data-space store
always @* begin
	acc_addr = bit_io;
	acc_wr   = 1'b0;
	acc_data = bit_cur;
	if (bit_op) begin
		acc_wr   = 1'b1;
		acc_addr = bit_io; // RQ3
		if (SET_IO_BIT)
			acc_data = bit_cur | sel_mask; // RQ6
		else
			acc_data = bit_cur & ~sel_mask; // RQ6
	end else if (IO_WR) begin
		acc_wr   = 1'b1;
		acc_addr = IO_ADDR; // RQ8
		acc_data = IO_WDATA;
	end else if (DS_WR && ds_io_hit) begin
		acc_wr   = 1'b1;
		acc_addr = ds_io; // RQ9
		acc_data = DS_WDATA;
	end
end

////////////////////////////////////////////////////////////////////////////////
// register update

// next stored value: masked write, then clear, then set by events
function [DW-1:0] nxt_val;
	input [5:0] a;
	reg   [DW-1:0] cur;
	reg   [DW-1:0] wm;
	reg   [DW-1:0] cm;
	begin
		cur = mem_ff[a];
		wm  = wr_mask(a);
		cm  = w1c_mask(a);
		if (acc_wr && acc_addr == a) begin
			cur = (cur & ~wm) | (acc_data & wm); // RQ11
			cur = cur & ~(acc_data & cm); // RQ5
		end
		// set wins over a same-cycle clear
		nxt_val = cur | (evt_bits(a) & cm); // RQ5
	end
endfunction

integer i;

// stored registers
always @(posedge SYS_CLK) begin
	for (i = 0; i < 64; i = i + 1) begin
		if (SYS_RST) begin
			mem_ff[i] <= `REG_RESET;
		end else begin
			mem_ff[i] <= nxt_val(i[5:0]);
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// read and test answers

// read answer, one cycle after the request
always @(posedge SYS_CLK) begin
	if (SYS_RST) begin
		read_data_ff  <= `REG_RESET;
		read_valid_ff <= 1'b0;
	end else begin
		read_valid_ff <= IO_RD | DS_RD;
		if (IO_RD)
			read_data_ff <= rd_value(IO_ADDR); // RQ8
		else if (DS_RD && ds_io_hit)
			read_data_ff <= rd_value(ds_io); // RQ9
		else if (DS_RD && ds_ext)
			read_data_ff <= EXT_RDATA; // RQ10
		else if (DS_RD)
			read_data_ff <= `REG_RESET;
	end
end

// bit test answer; skip holds until the next test
always @(posedge SYS_CLK) begin
	if (SYS_RST) begin
		skip_ff      <= 1'b0;
		test_done_ff <= 1'b0;
	end else begin
		test_done_ff <= test_req;
		if (test_req && bit_hi)
			skip_ff <= SKIP_IF_IO_BIT_SET; // RQ4
		else if (test_req)
			skip_ff <= SKIP_IF_IO_BIT_CLEAR; // RQ4
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign EXT_ADDR      = DS_ADDR;
assign EXT_RD        = DS_RD & ds_ext; // RQ10
assign EXT_WR        = DS_WR & ds_ext & ~bit_op & ~IO_WR; // RQ10
assign EXT_WDATA     = DS_WDATA;
assign READ_DATA     = read_data_ff;
assign READ_VALID    = read_valid_ff;
assign SKIP          = skip_ff;
assign TEST_DONE     = test_done_ff;
assign PORT_A_DIR    = mem_ff[`A_PORT_A_DIR];
assign PORT_A_OUT    = mem_ff[`A_PORT_A_OUT];
assign PORT_B_DIR    = mem_ff[`A_PORT_B_DIR];
assign PORT_B_OUT    = mem_ff[`A_PORT_B_OUT];
assign PORT_C_DIR    = mem_ff[`A_PORT_C_DIR];
assign PORT_C_OUT    = mem_ff[`A_PORT_C_OUT];
assign PORT_D_DIR    = mem_ff[`A_PORT_D_DIR];
assign PORT_D_OUT    = mem_ff[`A_PORT_D_OUT];
assign EXT_IRQ_MASK  = mem_ff[`A_EXT_IRQ_MASK] & `M_EXT_IRQ_MASK;
assign EXT_IRQ_FLAGS = mem_ff[`A_EXT_IRQ_FLAGS] & `M_EXT_IRQ_FLAGS;

endmodule // io_register_space_decode

// ==== hw/io_space_regs.vh ====
// register offsets, field masks, reset values and decode limits of the i/o register window
`ifndef IO_SPACE_REGS_VH
`define IO_SPACE_REGS_VH

// i/o window and data-space decode
`define IO_WIN_LAST       6'h3f
`define IO_BIT_LAST       6'h1f
`define DS_IO_BASE        8'h20
`define DS_EXT_BASE       8'h60
`define DS_EXT_LAST       8'hff

// i/o register offsets
`define A_PORT_A_PIN      6'h00
`define A_PORT_A_DIR      6'h01
`define A_PORT_A_OUT      6'h02
`define A_PORT_B_PIN      6'h03
`define A_PORT_B_DIR      6'h04
`define A_PORT_B_OUT      6'h05
`define A_PORT_C_PIN      6'h06
`define A_PORT_C_DIR      6'h07
`define A_PORT_C_OUT      6'h08
`define A_PORT_D_PIN      6'h09
`define A_PORT_D_DIR      6'h0a
`define A_PORT_D_OUT      6'h0b
`define A_TIMER0_FLAGS    6'h15
`define A_TIMER1_FLAGS    6'h16
`define A_TIMER2_FLAGS    6'h17
`define A_PIN_CHG_FLAGS   6'h1b
`define A_EXT_IRQ_FLAGS   6'h1c
`define A_EXT_IRQ_MASK    6'h1d
`define A_SCRATCH_0       6'h1e
`define A_EEPROM_CTRL     6'h1f
`define A_EEPROM_DATA     6'h20
`define A_EEPROM_ADDR_LO  6'h21
`define A_EEPROM_ADDR_HI  6'h22
`define A_GLOBAL_TMR_CTRL 6'h23
`define A_TIMER0_CTRL_A   6'h24
`define A_TIMER0_CTRL_B   6'h25
`define A_TIMER0_COUNT    6'h26
`define A_TIMER0_CMP_A    6'h27
`define A_TIMER0_CMP_B    6'h28
`define A_SCRATCH_1       6'h2a
`define A_SCRATCH_2       6'h2b
`define A_SERIAL_CTRL     6'h2c
`define A_SERIAL_STATUS   6'h2d
`define A_SERIAL_DATA     6'h2e
`define A_COMP_CTRL_STAT  6'h30
`define A_DEBUG_DATA      6'h31
`define A_SLEEP_CTRL      6'h33
`define A_RESET_CAUSE     6'h34
`define A_CORE_CTRL       6'h35
`define A_SELF_PROG_CTRL  6'h37

// implemented-bit masks (reserved bits are zero)
`define M_FULL            8'hff
`define M_NONE            8'h00
`define M_TIMER0_FLAGS    8'h07
`define M_TIMER1_FLAGS    8'h27
`define M_TIMER2_FLAGS    8'h07
`define M_PIN_CHG_FLAGS   8'h0f
`define M_EXT_IRQ_FLAGS   8'h07
`define M_EXT_IRQ_MASK    8'h07
`define M_EEPROM_CTRL     8'h3f
`define M_GLOBAL_TMR_CTRL 8'h83
`define M_TIMER0_CTRL_A   8'hf3
`define M_TIMER0_CTRL_B   8'hcf
`define M_SERIAL_STATUS   8'hc1
`define M_COMP_CTRL_RW    8'hef
`define M_COMP_CTRL_W1C   8'h10
`define M_SLEEP_CTRL      8'h0f
`define M_RESET_CAUSE     8'h1f
`define M_CORE_CTRL       8'hf3

// reset value of every stored register
`define REG_RESET         8'h00

`endif

// ==== sim/ext_periph_model.sv ====
// extended-region peripheral model
`timescale 1ns/1ns
module ext_periph_model (
	input  logic       SYS_CLK,
	input  logic [7:0] EXT_ADDR,
	input  logic       EXT_RD,
	input  logic       EXT_WR,
	input  logic [7:0] EXT_WDATA,
	output logic [7:0] EXT_RDATA
);
	logic [7:0] mem_ff [0:255];
	always @(posedge SYS_CLK) begin
		if (EXT_WR)
			mem_ff[EXT_ADDR] <= EXT_WDATA;
	end
	// idle: inverse, so stale data never matches
	assign EXT_RDATA = EXT_RD ? mem_ff[EXT_ADDR] : ~mem_ff[EXT_ADDR];
endmodule // ext_periph_model

// ==== sim/io_space_chk.sv ====
// assertion checker for the i/o window decode
`timescale 1ns/1ns
module io_space_chk (
	input logic       SYS_CLK,
	input logic       SYS_RST,
	input logic [5:0] IO_ADDR,
	input logic       IO_RD,
	input logic       IO_WR,
	input logic [7:0] IO_WDATA,
	input logic       SET_IO_BIT,
	input logic       CLEAR_IO_BIT,
	input logic       SKIP_IF_IO_BIT_SET,
	input logic       SKIP_IF_IO_BIT_CLEAR,
	input logic [7:0] DS_ADDR,
	input logic       DS_RD,
	input logic       DS_WR,
	input logic [7:0] DS_WDATA,
	input logic [7:0] EXT_ADDR,
	input logic       EXT_RD,
	input logic       EXT_WR,
	input logic       READ_VALID,
	input logic       TEST_DONE,
	input logic [7:0] PORT_A_OUT
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	property p_rdv; (IO_RD || DS_RD) |=> READ_VALID; endproperty
	property p_rdonly; READ_VALID |-> $past(IO_RD) || $past(DS_RD); endproperty
	property p_tst; (SKIP_IF_IO_BIT_SET || SKIP_IF_IO_BIT_CLEAR) |=> TEST_DONE; endproperty
	property p_extrd; EXT_RD == (DS_RD && DS_ADDR >= 8'h60); endproperty
	property p_extwr;
		EXT_WR == (DS_WR && DS_ADDR >= 8'h60 && !IO_WR && !SET_IO_BIT && !CLEAR_IO_BIT);
	endproperty
	property p_exta; EXT_RD |-> EXT_ADDR == DS_ADDR; endproperty
	property p_iowr;
		IO_WR && IO_ADDR == 6'h02 && !SET_IO_BIT && !CLEAR_IO_BIT
			|=> PORT_A_OUT == $past(IO_WDATA);
	endproperty
	property p_alias;
		DS_WR && DS_ADDR == 8'h22 && !IO_WR && !SET_IO_BIT && !CLEAR_IO_BIT
			|=> PORT_A_OUT == $past(DS_WDATA);
	endproperty
	a_rdv: assert property (p_rdv) else $error("read not answered");
	a_rdonly: assert property (p_rdonly) else $error("stray read valid");
	a_tst: assert property (p_tst) else $error("bit test not answered");
	a_extrd: assert property (p_extrd) else $error("ext read decode");
	a_extwr: assert property (p_extwr) else $error("ext write decode");
	a_exta: assert property (p_exta) else $error("ext address");
	a_iowr: assert property (p_iowr) else $error("io write lost");
	a_alias: assert property (p_alias) else $error("alias write lost");
	cover property (DS_RD && DS_ADDR >= 8'h60);
	cover property (TEST_DONE);
	cover property (SET_IO_BIT);
endmodule // io_space_chk

bind io_register_space_decode io_space_chk chk_i (.*);

// ==== sim/io_register_space_decode_tb_top.sv ====
// self-checking bench for the i/o window decode
`timescale 1ns/1ns
module io_register_space_decode_tb_top;
	localparam IOW = 0, IOR = 1, DSW = 2, DSR = 3, SETB = 4, CLRB = 5, TSET = 6, TCLR = 7;
	logic        SYS_CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic [7:0]  stb = 8'h00, addr = 8'h00, wd = 8'h00, pin_r = 8'h00, ev = 8'h00;
	logic [2:0]  bsel = 3'h0;
	logic [7:0]  ext_a, ext_wd, ext_rdd, rdata, want, q[$];
	logic        ext_rd, ext_wr, rvalid, skip, tdone;
	logic [7:0]  po [0:7];
	logic [7:0]  irq_m, irq_f;
	logic [31:0] rnd = 32'hc07502de;
	int          mismatches = 0;
	int          n_checks = 0;
	int          i;

	io_register_space_decode uut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .IO_ADDR(addr[5:0]),
		.IO_RD(stb[1]), .IO_WR(stb[0]), .IO_WDATA(wd), .BIT_ADDR(addr[4:0]), .BIT_SEL(bsel),
		.SET_IO_BIT(stb[4]), .CLEAR_IO_BIT(stb[5]), .SKIP_IF_IO_BIT_SET(stb[6]),
		.SKIP_IF_IO_BIT_CLEAR(stb[7]), .DS_ADDR(addr), .DS_RD(stb[3]), .DS_WR(stb[2]),
		.DS_WDATA(wd), .EXT_RDATA(ext_rdd), .PIN_A(pin_r), .PIN_B(pin_r), .PIN_C(pin_r),
		.PIN_D(pin_r), .TIMER0_EVENTS(ev), .TIMER1_EVENTS(ev), .TIMER2_EVENTS(ev),
		.PIN_CHG_EVENTS(ev), .EXT_IRQ_EVENTS(ev), .COMP_EVENT(ev[4]), .EXT_ADDR(ext_a),
		.EXT_RD(ext_rd), .EXT_WR(ext_wr), .EXT_WDATA(ext_wd), .READ_DATA(rdata),
		.READ_VALID(rvalid), .SKIP(skip), .TEST_DONE(tdone), .PORT_A_DIR(po[0]),
		.PORT_A_OUT(po[1]), .PORT_B_DIR(po[2]), .PORT_B_OUT(po[3]), .PORT_C_DIR(po[4]),
		.PORT_C_OUT(po[5]), .PORT_D_DIR(po[6]), .PORT_D_OUT(po[7]),
		.EXT_IRQ_MASK(irq_m), .EXT_IRQ_FLAGS(irq_f));
	ext_periph_model ext_i (.SYS_CLK(SYS_CLK), .EXT_ADDR(ext_a), .EXT_RD(ext_rd),
		.EXT_WR(ext_wr), .EXT_WDATA(ext_wd), .EXT_RDATA(ext_rdd));

	initial forever #20 SYS_CLK = ~SYS_CLK;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// one request pulse; reads and tests queue their expectation
	task op(input int k, input logic [7:0] a, input logic [7:0] d, input logic [2:0] b);
		@(negedge SYS_CLK);
		stb = 8'h01 << k;
		addr = a;
		wd = d;
		bsel = b;
		if (k == IOR || k == DSR || k > CLRB)
			q.push_back(d);
		@(negedge SYS_CLK);
		stb = 8'h00;
	endtask

	task cmp_byte(input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t read %h want %h", $time, g, e);
		end
	endtask

	task cmp_bit(input logic [7:0] e, input logic g);
		n_checks++;
		if (g !== e[0]) begin
			mismatches++;
			$display("[FAIL] %0t skip %b want %b", $time, g, e[0]);
		end
	endtask

	always @(posedge SYS_CLK) begin
		#1;
		if (rvalid === 1'b1)
			cmp_byte(q.pop_front(), rdata);
		if (tdone === 1'b1)
			cmp_bit(q.pop_front(), skip);
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		wrap_up;
	end

	initial begin
		repeat (6) @(negedge SYS_CLK);
		SYS_RST = 1'b0;
		for (i = 0; i < 12; i++)
			op(IOR, i, 8'h00, 0);
		op(IOW, 8'h02, 8'ha5, 0);
		op(IOR, 8'h02, 8'ha5, 0);
		op(DSR, 8'h22, 8'ha5, 0);
		rnd = xs(rnd);
		op(DSW, 8'h2b, rnd[7:0], 0);
		op(IOR, 8'h0b, rnd[7:0], 0);
		op(DSW, 8'h22, rnd[15:8], 0);
		op(IOR, 8'h02, rnd[15:8], 0);
		rnd = xs(rnd);
		pin_r = rnd[7:0];
		op(IOW, 8'h00, ~pin_r, 0);
		op(IOR, 8'h00, pin_r, 0);
		op(DSR, 8'h23, pin_r, 0);
		op(IOW, 8'h23, 8'hff, 0);
		op(IOR, 8'h23, 8'h83, 0);
		op(IOR, 8'h0c, 8'h00, 0);
		op(IOW, 8'h1d, 8'hff, 0);
		cmp_byte(8'h07, irq_m);
		op(IOR, 8'h1d, 8'h07, 0);
		op(DSR, 8'h10, 8'h00, 0);
		op(DSW, 8'h80, rnd[15:8], 0);
		op(DSR, 8'h80, rnd[15:8], 0);
		op(DSW, 8'hff, rnd[23:16], 0);
		op(DSR, 8'hff, rnd[23:16], 0);
		$display("test access done");
		for (i = 0; i < 8; i++) begin
			op(IOW, i + i / 2 + 1, 8'h11 * (i + 1), 0);
			cmp_byte(8'h11 * (i + 1), po[i]);
		end
		$display("test port outputs done");
		rnd = xs(rnd);
		want = rnd[7:0];
		op(IOW, 8'h05, want, 0);
		for (i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			want[i] = rnd[0];
			op(rnd[0] ? SETB : CLRB, 8'h05, 8'h00, i);
			op(TSET, 8'h05, {7'h00, want[i]}, i);
			op(TCLR, 8'h05, {7'h00, ~want[i]}, i);
		end
		op(IOR, 8'h05, want, 0);
		$display("test bit access done");
		@(negedge SYS_CLK) ev = 8'h05;
		@(negedge SYS_CLK) ev = 8'h00;
		cmp_byte(8'h05, irq_f);
		op(IOR, 8'h15, 8'h05, 0);
		op(IOW, 8'h15, 8'h00, 0);
		op(IOR, 8'h15, 8'h05, 0);
		op(IOW, 8'h15, 8'h01, 0);
		op(IOR, 8'h15, 8'h04, 0);
		op(TSET, 8'h1c, 8'h01, 2);
		op(SETB, 8'h15, 8'h00, 1);
		op(IOR, 8'h15, 8'h00, 0);
		op(CLRB, 8'h16, 8'h00, 3);
		op(IOR, 8'h16, 8'h00, 0);
		repeat (3) @(negedge SYS_CLK);
		$display("test flag clearing done");
		wrap_up;
	end
endmodule // io_register_space_decode_tb_top
